// File: rtl/epiu_top.sv
// external pin interrupt unit: eight pin detectors, cause flags, request lines, AHB-Lite slave
// assumes pins synchronous to hclk and a single AHB-Lite master issuing word transfers
// Summary of operation
// RL1: eight pin channels, each raising a request when its condition is seen
// RL2: each channel picks high level, low level, rising edge or falling edge
// RL3: two-bit select per channel, channels 0-3 low byte, 4-7 high byte
// RL4: one enable bit per channel gates that channel's request toward the cpu
// RL5: per-channel cause flag latched on detection, readable and writable
// RL6: eight channels feed four request lines, interrupt numbers 18, 20, 22, 24
// RL7: cpu runs the automatic transfer first when its service bit is one
// RL8: request while flag and enable both one; flag cleared only by writing zero
//
// The implementer's own choice: the AHB-Lite register port.
`timescale 1ns/10ps
module epiu_top
#(
	parameter int NUM_CHAN = epiu_pkg::NUM_CHAN,
	parameter int NUM_REQ  = epiu_pkg::NUM_REQ
)
(
	input  wire logic                hclk,
	input  wire logic                hresetn,
	input  wire logic                hsel,
	input  wire logic [31:0]         haddr,
	input  wire logic [1:0]          htrans,
	input  wire logic                hwrite,
	input  wire logic [2:0]          hsize,
	input  wire logic [31:0]         hwdata,
	input  wire logic                hready,
	output logic                     hreadyout,
	output logic                     hresp,
	output logic [31:0]              hrdata,
	input  wire logic [NUM_CHAN-1:0] ext_irq_pin,
	output logic [NUM_REQ-1:0]       irq_request,
	output logic                     irq
);

	epiu_pkg::epiu_aphase_s  aph_reg;
	epiu_pkg::epiu_aphase_s  aph_next;
	logic [NUM_CHAN-1:0]     enable_reg;
	logic [NUM_CHAN-1:0]     enable_next;
	logic [NUM_CHAN-1:0]     cause_reg;
	logic [NUM_CHAN-1:0]     cause_next;
	logic [2*NUM_CHAN-1:0]   config_reg;
	logic [2*NUM_CHAN-1:0]   config_next;
	logic [NUM_CHAN-1:0]     status_reg;
	logic [NUM_CHAN-1:0]     status_next;
	logic [NUM_CHAN-1:0]     mask_reg;
	logic [NUM_CHAN-1:0]     mask_next;
	logic [NUM_CHAN-1:0]     pin_reg;
	logic [NUM_CHAN-1:0]     pin_next;
	logic [31:0]             rdata_reg;
	logic [31:0]             rdata_next;
	logic [NUM_CHAN-1:0]     detect;
	logic [NUM_CHAN-1:0]     wr_byte;
	logic                    wr_en;
	logic                    wr_enable;
	logic                    wr_cause;
	logic                    wr_cfg_lo;
	logic                    wr_cfg_hi;
	logic                    wr_status;
	logic                    wr_mask;
	logic [7:0]              rd_idx;
	logic                    rd_go;

	// per-channel condition detector
	genvar ch;
	generate
		for (ch = 0; ch < NUM_CHAN; ch = ch + 1)
		begin : g_chan
			logic [1:0] sel;
			logic       rise;
			logic       fall;
			assign sel  = config_reg[2*ch +: 2]; // RL3
			// edges compare the pin with its sample from the previous edge
			assign rise = ext_irq_pin[ch] & ~pin_reg[ch];
			assign fall = ~ext_irq_pin[ch] & pin_reg[ch];
			always_comb
			begin
				case (sel) // RL2
					epiu_pkg::DET_LOW_LEVEL:    detect[ch] = ~ext_irq_pin[ch];
					epiu_pkg::DET_HIGH_LEVEL:   detect[ch] = ext_irq_pin[ch];
					epiu_pkg::DET_RISING_EDGE:  detect[ch] = rise;
					epiu_pkg::DET_FALLING_EDGE: detect[ch] = fall;
					default:                    detect[ch] = 1'b0;
				endcase
			end
		end
	endgenerate

	// request lines: channels paired onto four lines
	genvar rq;
	generate
		for (rq = 0; rq < NUM_REQ; rq = rq + 1)
		begin : g_req
			assign irq_request[rq] = |(cause_reg[2*rq +: 2] & enable_reg[2*rq +: 2]); // RL6 RL8 RL4
		end
	endgenerate

	assign irq       = |(status_reg & mask_reg);
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = rdata_reg;

	// data-phase write decode
	assign wr_en     = aph_reg.valid & aph_reg.write;
	assign wr_byte   = hwdata[NUM_CHAN-1:0];
	assign wr_enable = wr_en & (aph_reg.idx == epiu_pkg::IDX_CHANNEL_REQUEST_ENABLE);
	assign wr_cause  = wr_en & (aph_reg.idx == epiu_pkg::IDX_CHANNEL_CAUSE_FLAGS);
	assign wr_cfg_lo = wr_en & (aph_reg.idx == epiu_pkg::IDX_DETECT_CONFIG_LOW);
	assign wr_cfg_hi = wr_en & (aph_reg.idx == epiu_pkg::IDX_DETECT_CONFIG_HIGH);
	assign wr_status = wr_en & (aph_reg.idx == epiu_pkg::IDX_IRQ_STATUS);
	assign wr_mask   = wr_en & (aph_reg.idx == epiu_pkg::IDX_IRQ_MASK);
	assign rd_idx    = haddr[epiu_pkg::ADDR_IDX_MSB:epiu_pkg::ADDR_IDX_LSB];

	// read strobe; only a taken read reloads the read data
	assign rd_go = hsel & hready & htrans[1] & ~hwrite;

	// bus address phase capture
	always_comb
	begin
		aph_next.valid = hsel & hready & htrans[1];
		aph_next.write = hwrite;
		aph_next.idx   = rd_idx;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			aph_reg <= '0;
		end
		else
		begin
			aph_reg <= aph_next;
		end
	end

	// read data, loaded in the address phase and held until the next read
	always_comb
	begin
		rdata_next = rdata_reg;
		if (rd_go)
		begin
			rdata_next = 32'h0000_0000;
			case (rd_idx)
				epiu_pkg::IDX_CHANNEL_REQUEST_ENABLE: rdata_next[7:0] = enable_reg;
				epiu_pkg::IDX_CHANNEL_CAUSE_FLAGS:    rdata_next[7:0] = cause_reg; // RL5
				epiu_pkg::IDX_DETECT_CONFIG_LOW:      rdata_next[7:0] = config_reg[7:0];
				epiu_pkg::IDX_DETECT_CONFIG_HIGH:     rdata_next[7:0] = config_reg[15:8];
				epiu_pkg::IDX_IRQ_STATUS:             rdata_next[7:0] = status_reg;
				epiu_pkg::IDX_IRQ_MASK:               rdata_next[7:0] = mask_reg;
				epiu_pkg::IDX_PIN_LEVEL:              rdata_next[7:0] = pin_reg;
				default:                              rdata_next = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			rdata_reg <= 32'h0000_0000;
		end
		else
		begin
			rdata_reg <= rdata_next;
		end
	end

	// channel request enable
	always_comb
	begin
		enable_next = enable_reg;
		if (wr_enable)
		begin
			enable_next = wr_byte; // RL4
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			enable_reg <= epiu_pkg::RST_ENABLE;
		end
		else
		begin
			enable_reg <= enable_next;
		end
	end

	// detection select, two bytes
	always_comb
	begin
		config_next = config_reg;
		if (wr_cfg_lo)
		begin
			config_next[7:0] = hwdata[7:0]; // RL3
		end
		if (wr_cfg_hi)
		begin
			config_next[15:8] = hwdata[7:0]; // RL3
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			config_reg <= epiu_pkg::RST_CONFIG;
		end
		else
		begin
			config_reg <= config_next;
		end
	end

	// cause flags: a zero written clears, a one keeps; detection wins over clear
	always_comb
	begin
		cause_next = cause_reg;
		if (wr_cause)
		begin
			cause_next = cause_reg & wr_byte; // RL8
		end
		cause_next = cause_next | detect; // RL1 RL5
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			cause_reg <= epiu_pkg::RST_CAUSE;
		end
		else
		begin
			cause_reg <= cause_next;
		end
	end

	// interrupt status: a one written clears; detection wins over clear
	always_comb
	begin
		status_next = status_reg;
		if (wr_status)
		begin
			status_next = status_reg & ~wr_byte;
		end
		status_next = status_next | detect;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			status_reg <= epiu_pkg::RST_STATUS;
		end
		else
		begin
			status_reg <= status_next;
		end
	end

	// interrupt mask
	always_comb
	begin
		mask_next = mask_reg;
		if (wr_mask)
		begin
			mask_next = wr_byte;
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			mask_reg <= epiu_pkg::RST_MASK;
		end
		else
		begin
			mask_reg <= mask_next;
		end
	end

	// pin sample for edge detection
	always_comb
	begin
		pin_next = ext_irq_pin;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			pin_reg <= epiu_pkg::RST_PIN;
		end
		else
		begin
			pin_reg <= pin_next;
		end
	end

endmodule : epiu_top

// File: rtl/epiu_pkg.sv
// package for the external pin interrupt unit: register map, field layout, reset values
// assumes a 32-bit AHB-Lite register bus, one byte register per aligned word
package epiu_pkg;

	localparam int NUM_CHAN = 8;
	localparam int NUM_REQ  = 4;

	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_CHANNEL_REQUEST_ENABLE = 8'h3c;
	localparam logic [7:0] IDX_CHANNEL_CAUSE_FLAGS    = 8'h3d;
	localparam logic [7:0] IDX_DETECT_CONFIG_LOW      = 8'h3e;
	localparam logic [7:0] IDX_DETECT_CONFIG_HIGH     = 8'h3f;
	localparam logic [7:0] IDX_IRQ_STATUS             = 8'h40;
	localparam logic [7:0] IDX_IRQ_MASK               = 8'h41;
	localparam logic [7:0] IDX_PIN_LEVEL              = 8'h42;

	// word address field inside haddr
	localparam int ADDR_IDX_LSB = 2;
	localparam int ADDR_IDX_MSB = 9;

	localparam logic [7:0]  RST_ENABLE = 8'h00;
	localparam logic [7:0]  RST_CAUSE  = 8'h00;
	localparam logic [15:0] RST_CONFIG = 16'h0000;
	localparam logic [7:0]  RST_STATUS = 8'h00;
	localparam logic [7:0]  RST_MASK   = 8'h00;
	localparam logic [7:0]  RST_PIN    = 8'h00;

	// detection select, field {detect_sel_b, detect_sel_a}
	localparam logic [1:0] DET_LOW_LEVEL    = 2'h0;
	localparam logic [1:0] DET_HIGH_LEVEL   = 2'h1;
	localparam logic [1:0] DET_RISING_EDGE  = 2'h2;
	localparam logic [1:0] DET_FALLING_EDGE = 2'h3;

	localparam logic [1:0] HTRANS_NONSEQ_BIT = 2'h2;

	typedef struct packed {
		logic       valid;
		logic       write;
		logic [7:0] idx;
	} epiu_aphase_s;

endpackage : epiu_pkg

// File: sim/epiu_monitor.sv
// checker for the pin interrupt unit bus and request outputs
// bound to epiu_top from the bench top file
`timescale 1ns/10ps
module epiu_monitor
(
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [31:0] hwdata,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic [31:0] hrdata,
	input wire logic [3:0]  irq_request,
	input wire logic        irq
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	wire wr_go = hsel && htrans[1] && hwrite;
	wire rd_go = hsel && htrans[1] && !hwrite;
	wire [7:0] wr_idx = haddr[epiu_pkg::ADDR_IDX_MSB:epiu_pkg::ADDR_IDX_LSB];
	// write of zero to the enable register: address phase, then data phase
	sequence s_enable_off;
		wr_go && wr_idx == epiu_pkg::IDX_CHANNEL_REQUEST_ENABLE ##1 hwdata[7:0] == 8'h00;
	endsequence
	// write of zero to the mask register: address phase, then data phase
	sequence s_mask_off;
		wr_go && wr_idx == epiu_pkg::IDX_IRQ_MASK ##1 hwdata[7:0] == 8'h00;
	endsequence
	a_enable_off: assert property (s_enable_off |=> irq_request == 4'h0)
		else $error("request with all channels disabled");
	a_mask_off: assert property (s_mask_off |=> !irq)
		else $error("irq with all sources masked");
	a_ready_high: assert property (hreadyout) else $error("hreadyout low");
	a_resp_okay: assert property (!hresp) else $error("hresp not okay");
	a_byte_data: assert property (hrdata[31:8] == 24'h000000)
		else $error("hrdata upper bits set");
	a_release_clear: assert property ($rose(hresetn) |-> irq_request == 4'h0 && !irq)
		else $error("request after reset");
	a_req_sticky: assert property ($fell(|irq_request) |-> $past(wr_go, 2))
		else $error("request dropped without write");
	a_irq_sticky: assert property ($fell(irq) |-> $past(wr_go, 2))
		else $error("irq dropped without write");
	a_read_stands: assert property (!rd_go |=> $stable(hrdata))
		else $error("hrdata changed without read");
endmodule : epiu_monitor

// File: sim/epiu_pin_source.sv
// external interrupt sources: eight pins, changed just after a clock edge
`timescale 1ns/10ps
module epiu_pin_source
(
	input wire logic  hclk,
	output logic [7:0] ext_irq_pin
);
	initial ext_irq_pin = 8'h00;
	task automatic drive(input logic [7:0] v);
		@(posedge hclk);
		ext_irq_pin <= v;
	endtask : drive
endmodule : epiu_pin_source

// File: sim/epiu_top_tb.sv
// bench for the pin interrupt unit, AHB-Lite master tasks
// hready is looped back from hreadyout
`timescale 1ns/10ps
module epiu_top_tb;
	logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0]  htrans;
	logic [7:0]  pins;
	logic [3:0]  irq_request;
	logic [7:0]  ri [8] = '{8'h3c, 8'h3d, 8'h3e, 8'h3f, 8'h40, 8'h41, 8'h42, 8'h50};
	logic [7:0]  rv [8] = '{8'h00, 8'hff, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00};
	int          error_cnt = 0;
	int          checked = 0;
	initial
	begin
		hclk = 0;
		forever #20 hclk = ~hclk;
	end
	epiu_top epiu_top_inst(.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .ext_irq_pin(pins),
		.irq_request(irq_request), .irq(irq));
	epiu_pin_source epiu_pin_source_inst(.hclk(hclk), .ext_irq_pin(pins));
	task automatic bus(input logic [7:0] idx, input logic wr, input logic [7:0] d);
		hsel <= 1'b1;
		haddr <= {22'h0, idx, 2'h0};
		htrans <= 2'h2;
		hwrite <= wr;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask : bus
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e)
		begin
			error_cnt++;
			$display("ERROR %s exp %h got %h", nm, e, g);
		end
		@(posedge hclk);
	endtask : chk
	task automatic test_done;
		$display("checked %0d error_cnt %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : test_done
	initial
	begin
		#100000;
		error_cnt++;
		test_done;
	end
	initial
	begin
		{hresetn, hsel, haddr, htrans, hwrite, hwdata} = '0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		for (int i = 0; i < 8; i++)
		begin
			bus(ri[i], 1'b0, 8'h00);
			chk("reset", {24'h0, rv[i]}, rd);
		end
		bus(8'h3e, 1'b1, 8'h1e);
		bus(8'h3f, 1'b1, 8'h1e);
		epiu_pin_source_inst.drive(8'h66);
		bus(8'h3d, 1'b1, 8'h00);
		bus(8'h3d, 1'b0, 8'h00);
		chk("level", 32'hcc, rd);
		epiu_pin_source_inst.drive(8'h11);
		repeat (2) @(posedge hclk);
		bus(8'h3d, 1'b0, 8'h00);
		chk("edge", 32'hff, rd);
		bus(8'h3d, 1'b1, 8'h00);
		bus(8'h3d, 1'b0, 8'h00);
		chk("clear", 32'h88, rd);
		bus(8'h3d, 1'b1, 8'hff);
		bus(8'h3d, 1'b0, 8'h00);
		chk("noset", 32'h88, rd);
		bus(8'h3c, 1'b1, 8'h08);
		#1 chk("req", 32'h2, irq_request);
		bus(8'h3c, 1'b1, 8'h81);
		#1 chk("req", 32'h8, irq_request);
		bus(8'h41, 1'b1, 8'h01);
		#1 chk("irq", 32'h1, irq);
		bus(8'h40, 1'b1, 8'hff);
		#1 chk("irq", 32'h0, irq);
		bus(8'h41, 1'b1, 8'h08);
		#1 chk("irq", 32'h1, irq);
		epiu_pin_source_inst.drive(8'h00);
		epiu_pin_source_inst.drive(8'h11);
		bus(8'h3c, 1'b1, 8'h11);
		#1 chk("req", 32'h5, irq_request);
		bus(8'h40, 1'b0, 8'h00);
		chk("status", 32'h99, rd);
		bus(8'h42, 1'b0, 8'h00);
		chk("pin", 32'h11, rd);
		bus(8'h3c, 1'b1, 8'h00);
		#1 chk("req", 32'h0, irq_request);
		bus(8'h41, 1'b1, 8'h00);
		#1 chk("irq", 32'h0, irq);
		test_done;
	end
endmodule : epiu_top_tb
bind epiu_top epiu_monitor epiu_monitor_inst(.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
	.haddr(haddr), .hwdata(hwdata),
	.htrans(htrans), .hwrite(hwrite), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
	.irq_request(irq_request), .irq(irq));
